// ---- sctp_channel.v ----
/*
  one serial channel: uart transmit with cts handshake and parity, synchronous shift mode,
  uart/synchronous receive into a second buffer with overrun, parity and framing flags.
  assumes: serial_base_clock is a one-cycle strobe from the baud logic in the mclk domain;
  rxd_pin, clear_to_send_in_b and sync_clock_pin_i are asynchronous pins.
*/
`timescale 1ns/1ns
`include "sctp_map.vh"

// Operation
// - 4-bit counter of base clocks gives one transmit bit clock per 16 ticks.
// - sync clock-out mode drives each bit at the rising edge of our clock.
// - sync clock-in mode shifts each bit on the external edge chosen by edge select.
// - with handshake off, uart transmit starts at rising edge of the next bit clock after a write.
// - active-low clear-to-send input, gated by handshake enable in the mode register.
// - cts high lets the current frame finish, then holds until cts low again.
// - after cts falls, transmit begins at the first falling bit-clock edge.
// - transmit data shifts out lsb first on the transmit shift clock.
// - buffer is empty once the frame loads the shift register; transmit interrupt fires as the stop bit starts in uart, as the last bit starts in sync.
// - parity only in 7-bit and 8-bit uart with parity enable; sense picks even/odd.
// - transmit parity from written data, into bit 7 or the ninth bit.
// - receive parity over buffer two data compared to bit 7 or ninth bit.
// - overrun flag when a new word completes while buffer two is unread.
// - stop bit sampled three times; majority zero sets the framing flag.
// - receive interrupt and overrun check at the centre of the stop bit, or of the ninth bit in 9-bit mode and 8-bit with parity.
// - uart transmit interrupt fires in the same cycle the stop bit starts.
// - sync transmit interrupt follows the last active clock edge.
// - sync clock-out: each write sends 8 bits with clock, then interrupt.
// - sync clock-in: each write sends 8 bits on external clock, then interrupt.
// - received bits gather in a shift register, then move to buffer two.
// - two-bit frame mode: sync, 7-bit, 8-bit, 9-bit; no parity in 9-bit.
// - 9-bit mode sends the ninth bit field and stores the received ninth bit.
// - sync receive moves 8 bits to buffer two after the last clock.
module sctp_channel (
  input wire mclk,
  input wire rst_b,
  input wire ce,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rdata_q,
  input wire serial_base_clock,
  input wire rxd_pin,
  input wire clear_to_send_in_b,
  input wire sync_clock_pin_i,
  output reg sync_clock_pin_o_q,
  output reg sync_clock_pin_oe_b_q,
  output reg txd_q,
  output reg chan_tx_irq_q,
  output reg chan_rx_irq_q
);

  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_BITS = 2'h2;
  localparam RX_STOP = 2'h3;

  function sctp_par;
    input [7:0] d;
    input even;
    begin
      sctp_par = even ? ^d : ~^d;
    end
  endfunction

  // synchronisers: stage one is read only by stage two
  reg rxd_s1_q, rxd_s2_q, cts_s1_q, cts_s2_q;
  reg sck_s1_q, sck_s2_q, sck_s3_q;

  reg [7:0] mode_q;
  reg [1:0] ctrl_q;
  reg framing_error_flag_q, parity_error_flag_q, overrun_error_flag_q;

  reg [3:0] tx_cnt_q;
  reg [7:0] tx_data_q;
  reg tx_full_q, tx_busy_q, tx_on_fall_q;
  reg [9:0] tx_sr_q;
  reg [3:0] tx_left_q;
  reg [8:0] tx_frame_q;
  reg [3:0] tx_len_q;

  reg [1:0] rx_st_q;
  reg [3:0] rx_cnt_q;
  reg [1:0] rx_smp_q;
  reg [3:0] rx_idx_q;
  reg [8:0] rx_sr_q;
  reg rx_xfer_q;
  reg [7:0] rx_buf_q;
  reg rx_ninth_q, rx_valid_q;

  wire [1:0] fm = mode_q[1:0];
  wire uart = (fm != `SCTP_FM_SYNC);
  wire pe = ctrl_q[`SCTP_CTRL_PE] & (fm == `SCTP_FM_7BIT || fm == `SCTP_FM_8BIT);
  wire even = ctrl_q[`SCTP_CTRL_EVEN];
  wire dir_in = mode_q[`SCTP_MODE_DIR];
  wire tick = serial_base_clock;
  wire bclk_rise = tick && (tx_cnt_q == `SCTP_CNT_RISE);
  wire bclk_fall = tick && (tx_cnt_q == `SCTP_CNT_FALL);
  wire ext_rise = sck_s2_q & ~sck_s3_q;
  wire ext_fall = ~sck_s2_q & sck_s3_q;
  wire ext_edge = mode_q[`SCTP_MODE_EDGE] ? ext_fall : ext_rise;
  wire int_rise = tick && !sync_clock_pin_o_q && tx_busy_q;
  wire sync_edge = dir_in ? ext_edge : int_rise;
  wire cts_ok = !mode_q[`SCTP_MODE_HSE] || !cts_s2_q;
  wire tx_start = tx_full_q && !tx_busy_q && (uart ? (cts_ok &&
    (mode_q[`SCTP_MODE_HSE] ? bclk_fall : bclk_rise)) : 1'b1);
  wire tx_sft = tx_busy_q && (uart ? (tx_on_fall_q ? bclk_fall : bclk_rise) : sync_edge);
  wire rd_ctrl = rd_stb && (addr == `SCTP_ADDR_CTRL);
  wire rd_data = rd_stb && (addr == `SCTP_ADDR_DATA);

  wire rx_bit_done = tick && (rx_cnt_q == `SCTP_SMP_C);
  wire rx_bit = (rx_smp_q[0] & rx_smp_q[1]) | (rx_smp_q[0] & rxd_s2_q) |
    (rx_smp_q[1] & rxd_s2_q);
  wire [3:0] rx_nbits = (fm == `SCTP_FM_9BIT || (fm == `SCTP_FM_8BIT && pe)) ? 4'h9 : 4'h8;
  wire rx_early = (rx_nbits == 4'h9);

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
      cts_s1_q <= 1'b1;
      cts_s2_q <= 1'b1;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
    end else if (ce) begin
      rxd_s1_q <= rxd_pin;
      rxd_s2_q <= rxd_s1_q;
      cts_s1_q <= clear_to_send_in_b;
      cts_s2_q <= cts_s1_q;
      sck_s1_q <= sync_clock_pin_i;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
    end
  end

  // register port and transmit frame setup
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= `SCTP_MODE_RST;
      ctrl_q <= `SCTP_CTRL_RST;
      rdata_q <= 8'h00;
      tx_data_q <= 8'h00;
      tx_frame_q <= 9'h1ff;
      tx_len_q <= 4'h8;
    end else if (ce) begin
      if (wr_stb) begin
        case (addr)
          `SCTP_ADDR_MODE: mode_q <= {1'b0, wdata[6:0]};
          `SCTP_ADDR_CTRL: ctrl_q <= wdata[1:0];
          `SCTP_ADDR_DATA: begin
            tx_data_q <= wdata;
            // parity uses the enable and sense already set by software
            case (fm)
              `SCTP_FM_7BIT: begin
                tx_frame_q <= {1'b1, pe ? sctp_par({1'b0, wdata[6:0]}, even) : wdata[7],
                  wdata[6:0]};
                tx_len_q <= 4'h8;
              end
              `SCTP_FM_8BIT: begin
                tx_frame_q <= {pe ? sctp_par(wdata, even) : 1'b1, wdata};
                tx_len_q <= pe ? 4'h9 : 4'h8;
              end
              `SCTP_FM_9BIT: begin
                tx_frame_q <= {mode_q[`SCTP_MODE_TB8], wdata};
                tx_len_q <= 4'h9;
              end
              default: begin
                tx_frame_q <= {1'b1, wdata};
                tx_len_q <= `SCTP_SYNC_BITS;
              end
            endcase
          end
          default: ;
        endcase
      end
      if (rd_stb) begin
        case (addr)
          `SCTP_ADDR_MODE: rdata_q <= {rx_ninth_q, mode_q[6:0]};
          `SCTP_ADDR_CTRL: rdata_q <= {1'b0, rx_valid_q, tx_busy_q | tx_full_q,
            overrun_error_flag_q, parity_error_flag_q, framing_error_flag_q, ctrl_q};
          `SCTP_ADDR_DATA: rdata_q <= rx_buf_q;
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // transmit path
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_cnt_q <= 4'h0;
      tx_full_q <= 1'b0;
      tx_busy_q <= 1'b0;
      tx_on_fall_q <= 1'b0;
      tx_sr_q <= 10'h3ff;
      tx_left_q <= 4'h0;
      txd_q <= 1'b1;
      chan_tx_irq_q <= 1'b0;
      sync_clock_pin_o_q <= 1'b0;
      sync_clock_pin_oe_b_q <= 1'b1;
    end else if (ce) begin
      chan_tx_irq_q <= 1'b0;
      sync_clock_pin_oe_b_q <= !(fm == `SCTP_FM_SYNC && !dir_in);
      if (tick)
        tx_cnt_q <= tx_cnt_q + 4'h1;
      // own clock toggles once per base tick, finishing low after the last bit
      if (!uart && !dir_in && tick && (tx_busy_q || sync_clock_pin_o_q))
        sync_clock_pin_o_q <= !sync_clock_pin_o_q;
      if (wr_stb && addr == `SCTP_ADDR_DATA)
        tx_full_q <= 1'b1;
      else if (tx_start)
        tx_full_q <= 1'b0;
      if (tx_start) begin
        tx_busy_q <= 1'b1;
        tx_on_fall_q <= mode_q[`SCTP_MODE_HSE];
        if (uart) begin
          txd_q <= 1'b0;
          tx_sr_q <= {1'b1, (tx_len_q == 4'h9) ? tx_frame_q : {1'b1, tx_frame_q[7:0]}};
          tx_left_q <= tx_len_q + 4'h1;
        end else begin
          tx_sr_q <= {2'h3, tx_frame_q[7:0]};
          tx_left_q <= `SCTP_SYNC_BITS;
        end
      end else if (tx_sft) begin
        if (uart && tx_left_q == 4'h0) begin
          tx_busy_q <= 1'b0;
          txd_q <= 1'b1;
        end else begin
          txd_q <= tx_sr_q[0];
          tx_sr_q <= {1'b1, tx_sr_q[9:1]};
          tx_left_q <= tx_left_q - 4'h1;
          if (tx_left_q == 4'h1) begin
            chan_tx_irq_q <= 1'b1;
            if (!uart)
              tx_busy_q <= 1'b0;
          end
        end
      end
    end
  end

  // receive path
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= 4'h0;
      rx_smp_q <= 2'h3;
      rx_idx_q <= 4'h0;
      rx_sr_q <= 9'h000;
      rx_xfer_q <= 1'b0;
      rx_buf_q <= 8'h00;
      rx_ninth_q <= 1'b0;
      rx_valid_q <= 1'b0;
      framing_error_flag_q <= 1'b0;
      parity_error_flag_q <= 1'b0;
      overrun_error_flag_q <= 1'b0;
      chan_rx_irq_q <= 1'b0;
    end else if (ce) begin
      rx_xfer_q <= 1'b0;
      chan_rx_irq_q <= 1'b0;
      // flags clear on a control read; a same-cycle set wins below
      if (rd_ctrl) begin
        framing_error_flag_q <= 1'b0;
        parity_error_flag_q <= 1'b0;
        overrun_error_flag_q <= 1'b0;
      end
      if (rd_data)
        rx_valid_q <= 1'b0;
      if (tick)
        rx_cnt_q <= rx_cnt_q + 4'h1;
      if (tick && (rx_cnt_q == `SCTP_SMP_A || rx_cnt_q == `SCTP_SMP_B))
        rx_smp_q <= {rx_smp_q[0], rxd_s2_q};
      if (!mode_q[`SCTP_MODE_RXE]) begin
        rx_st_q <= RX_IDLE;
        rx_idx_q <= 4'h0;
      end else if (!uart) begin
        if (sync_edge) begin
          rx_sr_q[rx_idx_q[2:0]] <= rxd_s2_q;
          if (rx_idx_q == `SCTP_SYNC_BITS - 4'h1) begin
            rx_idx_q <= 4'h0;
            rx_xfer_q <= 1'b1;
          end else
            rx_idx_q <= rx_idx_q + 4'h1;
        end
      end else begin
        case (rx_st_q)
          RX_IDLE: begin
            if (!rxd_s2_q) begin
              rx_st_q <= RX_START;
              rx_cnt_q <= 4'h0;
            end
          end
          RX_START: begin
            if (rx_bit_done) begin
              rx_st_q <= rx_bit ? RX_IDLE : RX_BITS;
              rx_idx_q <= 4'h0;
            end
          end
          RX_BITS: begin
            if (rx_bit_done) begin
              rx_sr_q[rx_idx_q] <= rx_bit;
              rx_idx_q <= rx_idx_q + 4'h1;
              if (rx_idx_q == rx_nbits - 4'h1) begin
                rx_st_q <= RX_STOP;
                if (rx_early)
                  rx_xfer_q <= 1'b1;
              end
            end
          end
          RX_STOP: begin
            if (rx_bit_done) begin
              rx_st_q <= RX_IDLE;
              if (!rx_bit)
                framing_error_flag_q <= 1'b1;
              if (!rx_early)
                rx_xfer_q <= 1'b1;
            end
          end
          default: rx_st_q <= RX_IDLE;
        endcase
      end
      if (rx_xfer_q) begin
        chan_rx_irq_q <= 1'b1;
        if (rx_valid_q && !rd_data) begin
          overrun_error_flag_q <= 1'b1;
        end else begin
          rx_buf_q <= rx_sr_q[7:0];
          rx_valid_q <= 1'b1;
          if (rx_early)
            rx_ninth_q <= rx_sr_q[8];
          if (pe && fm == `SCTP_FM_7BIT &&
              sctp_par({1'b0, rx_sr_q[6:0]}, even) != rx_sr_q[7])
            parity_error_flag_q <= 1'b1;
          if (pe && fm == `SCTP_FM_8BIT && sctp_par(rx_sr_q[7:0], even) != rx_sr_q[8])
            parity_error_flag_q <= 1'b1;
        end
      end
    end
  end

endmodule // sctp_channel

// ---- sctp_channel_props.sv ----
/* port checks for sctp_channel.
   assumes: bound to sctp_channel with ce held high; mode writes are shadowed here. */
`timescale 1ns/1ns
module sctp_channel_props (
  input wire mclk,
  input wire rst_b,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [7:0] rdata_q,
  input wire serial_base_clock,
  input wire txd_q,
  input wire sync_clock_pin_o_q,
  input wire sync_clock_pin_oe_b_q,
  input wire chan_tx_irq_q,
  input wire chan_rx_irq_q
);
  reg [7:0] mode_q;
  wire uart = mode_q[1:0] != 2'h0;
  wire mwr = wr_stb && addr == 4'h0;
  // ce is not watched and bit 7 is kept as written, so this shadow matches bits 6:0 only, and only while ce stays high
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) mode_q <= 8'h00;
    else if (mwr) mode_q <= wdata;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_txd_on_tick: assert property (uart && $changed(txd_q) |-> $past(serial_base_clock))
    else $error("txd moved off a tick");
  a_irq_at_stop: assert property (uart && chan_tx_irq_q |-> txd_q && $past(serial_base_clock))
    else $error("tx irq not at stop start");
  a_stop_holds: assert property (uart && chan_tx_irq_q |-> txd_q [*8])
    else $error("stop bit too short");
  a_tx_irq_pulse: assert property (chan_tx_irq_q |=> !chan_tx_irq_q)
    else $error("tx irq longer than one cycle");
  a_rx_irq_pulse: assert property (chan_rx_irq_q |=> !chan_rx_irq_q)
    else $error("rx irq longer than one cycle");
  a_unmapped_zero: assert property (rd_stb && addr > 4'h2 |=> rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_oe_by_mode: assert property (mwr ##1 !mwr [*2]
    |-> sync_clock_pin_oe_b_q == (mode_q[1:0] != 2'h0 || mode_q[5]))
    else $error("clock pin enable wrong");
  a_sync_irq_rise: assert property (!uart && !mode_q[5] && chan_tx_irq_q
    |-> sync_clock_pin_o_q || $past(sync_clock_pin_o_q))
    else $error("sync tx irq not after a rise");
endmodule // sctp_channel_props
bind sctp_channel sctp_channel_props u_props (.mclk(mclk), .rst_b(rst_b), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q),
  .serial_base_clock(serial_base_clock), .txd_q(txd_q), .sync_clock_pin_o_q(sync_clock_pin_o_q),
  .sync_clock_pin_oe_b_q(sync_clock_pin_oe_b_q), .chan_tx_irq_q(chan_tx_irq_q),
  .chan_rx_irq_q(chan_rx_irq_q));

// ---- sctp_channel_tb.sv ----
/* bench for sctp_channel: uart peer, register tasks and a frame model.
   assumes: ce high; one base tick every 4 mclk, so one uart bit is 64 cycles. */
`timescale 1ns/1ns
module sctp_channel_tb;
  reg mclk = 1'b0;
  reg rst_b = 1'b0;
  reg wr_stb = 1'b0;
  reg rd_stb = 1'b0;
  reg sci = 1'b0;
  reg sco_d = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00;
  reg [1:0] cyc = 2'h0;
  reg [3:0] nb = 4'h8;
  reg [7:0] d, sreg, ci;
  reg [9:0] w;
  wire [7:0] rdata_q;
  wire rxd, cts_b, sco, sco_oe_b, txd, tx_irq, rx_irq;
  wire tick = cyc == 2'h0;
  int error_cnt, checks_done, txn, rxn, m, p, e, t;
  sctp_channel DUT (.mclk(mclk), .rst_b(rst_b), .ce(1'b1), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q), .serial_base_clock(tick),
    .rxd_pin(rxd), .clear_to_send_in_b(cts_b), .sync_clock_pin_i(sco_oe_b ? sci : sco),
    .sync_clock_pin_o_q(sco), .sync_clock_pin_oe_b_q(sco_oe_b), .txd_q(txd),
    .chan_tx_irq_q(tx_irq), .chan_rx_irq_q(rx_irq));
  sctp_peer peer (.mclk(mclk), .txd(txd), .nbits(nb), .rxd(rxd), .cts_b(cts_b));
  initial begin
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 2'h1;
    sco_d <= sco;
    if (sco_d && !sco) sreg <= {txd, sreg[7:1]};
    if (tx_irq === 1'b1) txn++;
    if (rx_irq === 1'b1) rxn++;
  end
  task chk(input [9:0] seen, input [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input [3:0] a, input [7:0] x);
    @(posedge mclk);
    addr <= a;
    wdata <= x;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task rdc(input [3:0] a, input [7:0] x);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 chk(rdata_q, x);
  endtask
  task frame_in(output [9:0] f);
    for (int i = 0; i < 3000 && peer.got_q.size() == 0; i++) @(posedge mclk);
    f = peer.got_q.size() ? peer.got_q.pop_front() : 10'h3ff;
    repeat (64) @(posedge mclk);
  endtask
  // data lsb first, then parity or ninth bit, stop high at bit n
  function automatic [9:0] model(input [1:0] md, input par, input ev, input t8,
    input [7:0] x, input [3:0] n);
    model = {2'h0, x};
    if (md == 2'h1 && par) model[7] = ~^{ev, x[6:0]};
    if (md == 2'h2) model[8] = ~^{ev, x};
    if (md == 2'h3) model[8] = t8;
    model[n] = 1'b1;
  endfunction
  task rx_case(input [9:0] f, input twice, input [7:0] ec);
    peer.send(f, 9);
    if (twice) peer.send(f ^ 10'h0ff, 9);
    repeat (8) @(posedge mclk);
    rdc(4'h1, ec);
    rdc(4'h2, f[7:0]);
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(82562));
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rdc(4'h0, 8'h00);
    rdc(4'h1, 8'h00);
    rdc(4'h3, 8'h00);
    $display("reset test done");
    for (m = 1; m < 4; m++) begin
      for (p = 0; p < 2; p++) begin
        d = $urandom;
        e = $urandom % 2;
        t = $urandom % 2;
        nb = (m == 1 || (m == 2 && p == 0)) ? 4'h8 : 4'h9;
        wr(4'h0, {3'h0, t[0], 2'h0, m[1:0]});
        wr(4'h1, {6'h00, e[0], p[0]});
        wr(4'h2, d);
        frame_in(w);
        chk(w, model(m, p, e, t, d, nb));
      end
    end
    chk(txn, 6);
    $display("uart transmit test done");
    nb = 4'h8;
    wr(4'h0, 8'h06);
    wr(4'h1, 8'h00);
    peer.cts_b <= 1'b1;
    repeat (4) @(posedge mclk);
    wr(4'h2, d);
    repeat (300) @(posedge mclk);
    chk(peer.got_q.size(), 0);
    peer.cts_b <= 1'b0;
    frame_in(w);
    chk(w, model(2, 0, 0, 0, d, 8));
    $display("handshake test done");
    wr(4'h0, 8'h0a);
    wr(4'h1, 8'h03);
    rx_case({1'b1, ~^d, d}, 0, 8'h4b);
    rx_case({1'b0, ^d, d}, 0, 8'h47);
    rx_case({1'b1, ^d, d}, 1, 8'h53);
    rdc(4'h1, 8'h03);
    chk(rxn, 4);
    $display("receive test done");
    wr(4'h0, 8'h00);
    d = $urandom;
    m = txn;
    wr(4'h2, d);
    for (int i = 0; i < 2000 && txn == m; i++) @(posedge mclk);
    repeat (16) @(posedge mclk);
    chk(sreg, d);
    chk(txn, m + 1);
    $display("sync clock out test done");
    wr(4'h0, 8'h20);
    d = $urandom;
    m = txn;
    wr(4'h2, d);
    repeat (8) begin
      repeat (10) @(posedge mclk);
      sci <= 1'b1;
      repeat (10) @(posedge mclk);
      ci = {txd, ci[7:1]};
      sci <= 1'b0;
    end
    repeat (10) @(posedge mclk);
    chk(ci, d);
    chk(txn, m + 1);
    $display("sync clock in test done");
    tally_and_finish;
  end
endmodule // sctp_channel_tb

// ---- sctp_map.vh ----
/*
  register offsets, field positions, reset values and bit-timing counts for the serial channel.
  assumes: included by the channel module only; definitions only.
*/
`ifndef SCTP_MAP_VH
`define SCTP_MAP_VH

`define SCTP_ADDR_MODE 4'h0
`define SCTP_ADDR_CTRL 4'h1
`define SCTP_ADDR_DATA 4'h2

`define SCTP_FM_SYNC 2'h0
`define SCTP_FM_7BIT 2'h1
`define SCTP_FM_8BIT 2'h2
`define SCTP_FM_9BIT 2'h3

`define SCTP_MODE_HSE 2
`define SCTP_MODE_RXE 3
`define SCTP_MODE_TB8 4
`define SCTP_MODE_DIR 5
`define SCTP_MODE_EDGE 6
`define SCTP_MODE_RB8 7

`define SCTP_CTRL_PE 0
`define SCTP_CTRL_EVEN 1
`define SCTP_CTRL_FRAMING_ERROR_FLAG 2
`define SCTP_CTRL_PARITY_ERROR_FLAG 3
`define SCTP_CTRL_OVERRUN_ERROR_FLAG 4
`define SCTP_CTRL_TXBUSY 5
`define SCTP_CTRL_RXVALID 6

`define SCTP_MODE_RST 8'h00
`define SCTP_CTRL_RST 2'h0

`define SCTP_CNT_RISE 4'h7
`define SCTP_CNT_FALL 4'hf
`define SCTP_SMP_A 4'h6
`define SCTP_SMP_B 4'h7
`define SCTP_SMP_C 4'h8
`define SCTP_SYNC_BITS 4'h8

`endif

// ---- sctp_peer.sv ----
/* remote uart peer: decodes frames from txd, sends frames on rxd, drives clear-to-send.
   assumes: one bit lasts 64 mclk cycles; nbits counts the bits between start and stop. */
`timescale 1ns/1ns
module sctp_peer (
  input wire mclk,
  input wire txd,
  input wire [3:0] nbits,
  output reg rxd,
  output reg cts_b
);
  reg [9:0] got_q[$];
  reg [9:0] w;
  initial begin
    rxd = 1'b1;
    cts_b = 1'b0;
  end
  // mid-bit sampling from the start edge; the stop level lands in w[nbits]
  always begin
    @(negedge txd);
    repeat (32) @(posedge mclk);
    w = 10'h000;
    for (int i = 0; i <= nbits; i++) begin
      repeat (64) @(posedge mclk);
      w[i] = txd;
    end
    got_q.push_back(w);
  end
  task send(input [9:0] f, input int n);
    rxd <= 1'b0;
    repeat (64) @(posedge mclk);
    for (int i = 0; i <= n; i++) begin
      rxd <= f[i];
      repeat (64) @(posedge mclk);
    end
    // one idle cycle so a following frame still shows a falling start edge
    rxd <= 1'b1;
    @(posedge mclk);
  endtask
endmodule // sctp_peer
